// *** pkg/mirc_pkg.sv ***
// Package: constants and types of the interrupt, reset and clock control block.
// Assumes a 32-bit classic Wishbone host and a 250 MHz system clock.
`default_nettype none
package mirc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_OPTION = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PC     = 8'h0c;
	localparam logic [7:0] OFS_SLOT   = 8'h10;
	// Control register fields and reset value
	localparam int         CTRL_MODE_LSB = 0;
	localparam int         CTRL_DIV_LSB  = 2;
	localparam int         CTRL_GPIN_BIT = 4;
	localparam int         CTRL_W        = 5;
	localparam logic [4:0] CTRL_RST      = 5'h00;
	// Option flag fields and reset value
	localparam int         OPT_ARM_BIT = 1;
	localparam int         OPT_SEG_BIT = 2;
	localparam logic [3:0] OPT_RST     = 4'h0;
	// Program counter width and fixed addresses
	localparam int          PC_W      = 11;
	localparam logic [10:0] PC_VECTOR = 11'h0ff;
	localparam logic [10:0] PC_RESET  = 11'h000;
	// Counts in instruction cycles, and the return stack depth in entries
	localparam int RST_HOLD_CYC = 3;
	localparam int IRQ_LOW_CYC  = 2;
	localparam int STACK_DEPTH  = 3;
	// Oscillator divide ratios
	localparam logic [5:0] DIV_32 = 6'h20;
	localparam logic [5:0] DIV_16 = 6'h10;
	localparam logic [5:0] DIV_8  = 6'h08;
	localparam logic [5:0] DIV_4  = 6'h04;
	// Pin synchroniser lanes
	localparam int PIN_OSC = 0;
	localparam int PIN_IRQ = 1;
	localparam int PIN_CKO = 2;
	localparam int PIN_RST = 3;
	localparam int PIN_N   = 4;
	typedef enum logic [1:0] {CM_CRYSTAL, CM_EXTERNAL, CM_RC, CM_SYNC} mirc_clk_mode_t;
	typedef enum logic [1:0] {DV_32, DV_16, DV_8, DV_SPARE} mirc_div_t;
endpackage : mirc_pkg
`default_nettype wire

// *** pkg/mirc_tick_if.sv ***
// Interface: instruction-cycle timing and interrupt request carrier.
// Assumes every member lives in the clk_i domain of the control block.
`timescale 1ns/100ps
`default_nettype none
interface mirc_tick_if;
	logic                     cyc_stb;  // One pulse per instruction cycle
	logic                     osc_lvl;  // Synchronised oscillator input
	logic                     sync_lvl; // Synchronised clock-output pin
	logic                     irq_lvl;  // Synchronised interrupt pin
	logic                     arm;      // Interrupt arm bit
	logic                     irq_take; // Request accepted this cycle
	logic                     irq_req;  // Qualified request pending
	mirc_pkg::mirc_clk_mode_t mode;
	mirc_pkg::mirc_div_t      div_sel;
	modport gen (input osc_lvl, input sync_lvl, input mode, input div_sel, output cyc_stb);
	modport qual (input cyc_stb, input irq_lvl, input arm, input irq_take, output irq_req);
endinterface : mirc_tick_if
`default_nettype wire

// *** rtl/mirc_clk_div.sv ***
// Instruction-cycle generator: divides the oscillator or follows the sync input.
// Assumes oscillator and sync levels are already synchronised to clk_i and are
// well below half the clk_i rate, otherwise edges are missed.
`timescale 1ns/100ps
`default_nettype none
module mirc_clk_div (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	mirc_tick_if.gen  tk
);
	logic       osc_q;
	logic       sync_q;
	logic       stb;
	logic [5:0] cnt;
	logic [5:0] ratio;
	logic       osc_rise;
	logic       sync_rise;

	assign osc_rise   = tk.osc_lvl && !osc_q;
	assign sync_rise  = tk.sync_lvl && !sync_q;
	assign tk.cyc_stb = stb;

	// Divide ratio per clock mode
	always_comb
	begin
		case (tk.mode)
			mirc_pkg::CM_RC: ratio = mirc_pkg::DIV_4;
			default:
			begin
				case (tk.div_sel)
					mirc_pkg::DV_16: ratio = mirc_pkg::DIV_16;
					mirc_pkg::DV_8:  ratio = mirc_pkg::DIV_8;
					default:         ratio = mirc_pkg::DIV_32;
				endcase
			end
		endcase
	end

	// Edge history, edge count and cycle strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_q  <= 1'b0;
			sync_q <= 1'b0;
			cnt    <= 6'h00;
			stb    <= 1'b0;
		end
		else if (ce_i)
		begin
			osc_q  <= tk.osc_lvl;
			sync_q <= tk.sync_lvl;
			if (tk.mode == mirc_pkg::CM_SYNC)
			begin
				cnt <= 6'h00;
				stb <= sync_rise; // Peer's pulse marks each cycle
			end
			else if (osc_rise)
			begin
				// A ratio change mid-cycle lands on the next wrap, never hangs
				cnt <= (cnt >= ratio - 6'h01) ? 6'h00 : cnt + 6'h01;
				stb <= (cnt >= ratio - 6'h01);
			end
			else
			begin
				stb <= 1'b0;
			end
		end
	end

	property p_div_wrap;
		@(posedge clk_i) disable iff (rst_i)
		$rose(stb) && $past(tk.mode) != mirc_pkg::CM_SYNC |-> $past(osc_rise)
			&& $past(cnt) >= $past(ratio) - 6'h01;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("cycle strobe off the divide count");
endmodule : mirc_clk_div
`default_nettype wire

// *** rtl/mirc_irq_qual.sv ***
// Interrupt pin qualifier: one sample per instruction cycle, sticky request.
// Assumes the pin level is synchronised and the strobe comes from the divider.
`timescale 1ns/100ps
`default_nettype none
module mirc_irq_qual #(
	parameter int LOW_CYC = mirc_pkg::IRQ_LOW_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	mirc_tick_if.qual tk
);
	logic [LOW_CYC:0] hist;
	logic [LOW_CYC:0] next_hist;
	logic             hit;
	logic             pend;

	if (LOW_CYC < 1)
	begin : g_chk
		$error("LOW_CYC must be at least 1");
	end

	assign next_hist  = {hist[LOW_CYC-1:0], tk.irq_lvl};
	// High sample then LOW_CYC low samples; shorter pulses never match
	assign hit        = tk.cyc_stb && tk.arm && (next_hist == {1'b1, {LOW_CYC{1'b0}}});
	assign tk.irq_req = pend;

	// Sample history, advanced once per instruction cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hist <= '0;
		end
		else if (ce_i && tk.cyc_stb)
		begin
			hist <= next_hist;
		end
	end

	// Pending request: a new hit wins over the acceptance clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pend <= 1'b0;
		end
		else if (ce_i)
		begin
			if (hit)
			begin
				pend <= 1'b1;
			end
			else if (tk.irq_take || !tk.arm)
			begin
				pend <= 1'b0;
			end
		end
	end

	property p_req_needs_low;
		@(posedge clk_i) disable iff (rst_i)
		$rose(pend) |-> $past(tk.arm) && !$past(tk.irq_lvl) && !$past(hist[0]);
	endproperty
	a_req_needs_low: assert property (p_req_needs_low) else $error("request without low pulse");

	property p_req_needs_arm;
		@(posedge clk_i) disable iff (rst_i)
		!tk.arm |=> !pend;
	endproperty
	a_req_needs_arm: assert property (p_req_needs_arm) else $error("request kept while disarmed");
endmodule : mirc_irq_qual
`default_nettype wire

// *** rtl/mirc_ctl.sv ***
// Interrupt, reset and clock control for a 4-bit controller core, Wishbone slave.
// Assumes a core that reports each finished instruction and its class, and
// pins that may change at any time relative to clk_i.
//
// Contract
// - Acknowledge pushes next address, stack shifts down
// - Acknowledge jumps to vector, clears arm bit
// - Acknowledge only while arm bit set
// - Request needs falling edge, two-cycle low
// - Acknowledge only after instruction completes
// - Defer through chained transfers or pointer loads
// - Save skip state, restore on next pop
// - Reset pin low three cycles initialises
// - Initialisation clears PC and core registers
// - Initialisation leaves data memory alone
// - Sync output pulses once per cycle; here it stays low until a reset-pin initialisation sets sync_en
// - Crystal or external divides by 32/16/8
// - RC mode divides by four
// - Sync mode takes cycle from clock-output pin
// - Latch read copies clock-output pin level; here only with CTRL_GPIN_BIT set in external or RC mode, else it reads 0
// - Software can switch segment drivers off
// - Interrupt pin active only with arm bit
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mirc_ctl #(
	parameter int STACK_DEPTH = mirc_pkg::STACK_DEPTH,
	parameter int RST_HOLD    = mirc_pkg::RST_HOLD_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins
	input  wire logic        clk_in_pin_i,
	input  wire logic        irq_pin_i,
	input  wire logic        reset_pin_n_i,
	input  wire logic        clk_out_pin_i,
	output logic             clk_out_pin_o,
	output logic             clk_out_pin_oe_o,
	output logic             sync_clk_out_o,
	output logic             seg_oe_o,
	// Core side
	input  wire logic        instr_done_i,
	input  wire logic        done_xfer_i,
	input  wire logic        done_ptr_i,
	input  wire logic        next_xfer_i,
	input  wire logic        next_ptr_i,
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic [10:0] target_pc_i,
	input  wire logic        skip_i,
	input  wire logic        flag_load_i,
	input  wire logic [3:0]  flag_data_i,
	input  wire logic        latch_read_i,
	output logic             cyc_stb_o,
	output logic      [10:0] pc_o,
	output logic             irq_ack_o,
	output logic             skip_restore_o,
	output logic             core_clear_o,
	output logic      [3:0]  option_o,
	output logic             acc_bit2_o
);
	localparam int PCW = mirc_pkg::PC_W;
	localparam int CW  = $clog2(RST_HOLD + 1);

	typedef enum logic [1:0] {IS_RUN, IS_LOW, IS_HELD} mirc_init_t;

	logic [mirc_pkg::PIN_N-1:0]      pin_raw;
	logic [mirc_pkg::PIN_N-1:0]      pin_sync;
	logic [mirc_pkg::CTRL_W-1:0]     ctrl;
	logic [3:0]                      opt;
	logic                            sync_en;
	logic [STACK_DEPTH-1:0][PCW:0]   stk;
	logic [PCW-1:0]                  push_pc;
	logic                            push_skip;
	logic                            chain;
	logic                            take;
	logic                            do_push;
	logic                            do_pop;
	logic                            init_hold;
	logic                            gpin_ok;
	logic                            bus_req;
	logic                            wr_ctrl;
	logic                            wr_opt;
	logic [31:0]                     rd_mux;
	logic [CW-1:0]                   low_cnt;
	mirc_init_t                      st;
	mirc_init_t                      next_st;

	mirc_tick_if tk ();

	if (STACK_DEPTH < 2 || STACK_DEPTH > 4)
	begin : g_chk_depth
		$error("STACK_DEPTH must be 2 to 4");
	end
	if (RST_HOLD < 1)
	begin : g_chk_hold
		$error("RST_HOLD must be at least 1");
	end

	assign pin_raw = {reset_pin_n_i, clk_out_pin_i, irq_pin_i, clk_in_pin_i};

	// Two-stage synchronisers; only the second stage is read
	for (genvar g = 0; g < mirc_pkg::PIN_N; g++)
	begin : g_sync
		logic meta;
		logic held;
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				meta <= (g == mirc_pkg::PIN_RST) || (g == mirc_pkg::PIN_IRQ);
				held <= (g == mirc_pkg::PIN_RST) || (g == mirc_pkg::PIN_IRQ);
			end
			else if (ce_i)
			begin
				meta <= pin_raw[g];
				held <= meta;
			end
		end
		assign pin_sync[g] = held;
	end

	// Timing and interrupt qualifier hookup
	assign tk.osc_lvl  = pin_sync[mirc_pkg::PIN_OSC];
	assign tk.sync_lvl = pin_sync[mirc_pkg::PIN_CKO]; // Pin is an input here
	assign tk.irq_lvl  = pin_sync[mirc_pkg::PIN_IRQ];
	assign tk.arm      = opt[mirc_pkg::OPT_ARM_BIT];
	assign tk.irq_take = take;
	assign tk.mode     = mirc_pkg::mirc_clk_mode_t'(ctrl[mirc_pkg::CTRL_MODE_LSB +: 2]);
	assign tk.div_sel  = mirc_pkg::mirc_div_t'(ctrl[mirc_pkg::CTRL_DIV_LSB +: 2]);
	assign cyc_stb_o   = tk.cyc_stb;

	mirc_clk_div u_div (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.tk    (tk)
	);

	mirc_irq_qual u_irq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.tk    (tk)
	);

	// Reset pin sequencing: initialise only after a long enough low
	always_comb
	begin
		next_st = st;
		case (st)
			IS_RUN:
			begin
				if (!pin_sync[mirc_pkg::PIN_RST])
				begin
					next_st = IS_LOW;
				end
			end
			IS_LOW:
			begin
				if (pin_sync[mirc_pkg::PIN_RST])
				begin
					next_st = IS_RUN;
				end
				else if (tk.cyc_stb && low_cnt == CW'(RST_HOLD - 1))
				begin
					next_st = IS_HELD;
				end
			end
			IS_HELD:
			begin
				if (pin_sync[mirc_pkg::PIN_RST])
				begin
					next_st = IS_RUN;
				end
			end
			default: next_st = IS_RUN;
		endcase
	end

	// State and low-time counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st      <= IS_RUN;
			low_cnt <= '0;
		end
		else if (ce_i)
		begin
			st <= next_st;
			if (st != IS_LOW)
			begin
				low_cnt <= '0;
			end
			else if (tk.cyc_stb)
			begin
				low_cnt <= low_cnt + CW'(1);
			end
		end
	end

	assign init_hold    = (st == IS_HELD);
	// Core clears its accumulator, pointer, carry and ports; memory is untouched
	assign core_clear_o = init_hold;

	// Acknowledge gating; stack instructions finish before a push can follow
	assign chain   = (done_xfer_i && next_xfer_i) || (done_ptr_i && next_ptr_i);
	assign take    = ce_i && instr_done_i && tk.irq_req && opt[mirc_pkg::OPT_ARM_BIT]
		&& !chain && !push_i && !pop_i && !init_hold;
	assign do_push = ce_i && instr_done_i && !init_hold && (take || push_i);
	assign do_pop  = ce_i && instr_done_i && !init_hold && pop_i && !take;
	// Interrupt pushes the address the finished instruction leads to
	assign push_pc   = take ? target_pc_i : pc_o + 11'h001;
	assign push_skip = take && skip_i;

	// Return stack: first slot on top, oldest entry falls off the bottom
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stk <= '0;
		end
		else if (do_push)
		begin
			stk <= {stk[STACK_DEPTH-2:0], {push_skip, push_pc}};
		end
		else if (do_pop)
		begin
			stk <= {stk[STACK_DEPTH-1], stk[STACK_DEPTH-1:1]};
		end
	end

	// Program counter and one-cycle event outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pc_o           <= mirc_pkg::PC_RESET;
			irq_ack_o      <= 1'b0;
			skip_restore_o <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_ack_o      <= take;
			// Vector's idle instruction absorbs the skip still live in the core
			skip_restore_o <= do_pop && stk[0][PCW];
			if (init_hold)
			begin
				pc_o <= mirc_pkg::PC_RESET;
			end
			else if (take)
			begin
				pc_o <= mirc_pkg::PC_VECTOR;
			end
			else if (do_pop)
			begin
				pc_o <= stk[0][PCW-1:0];
			end
			else if (instr_done_i)
			begin
				pc_o <= target_pc_i;
			end
		end
	end

	// Option flags: a flag load wins over the acknowledge clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			opt <= mirc_pkg::OPT_RST;
		end
		else if (ce_i)
		begin
			if (init_hold)
			begin
				opt <= mirc_pkg::OPT_RST;
			end
			else if (flag_load_i)
			begin
				opt <= flag_data_i;
			end
			else if (wr_opt)
			begin
				opt <= wb_dat_i[3:0];
			end
			else if (take)
			begin
				opt[mirc_pkg::OPT_ARM_BIT] <= 1'b0;
			end
		end
	end

	assign option_o = opt;
	assign seg_oe_o = opt[mirc_pkg::OPT_SEG_BIT]; // Low leaves segment pins floating
	assign gpin_ok  = ctrl[mirc_pkg::CTRL_GPIN_BIT]
		&& (tk.mode == mirc_pkg::CM_EXTERNAL || tk.mode == mirc_pkg::CM_RC);

	// Pin-facing outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_en          <= 1'b0;
			sync_clk_out_o   <= 1'b0;
			clk_out_pin_o    <= 1'b0;
			clk_out_pin_oe_o <= 1'b0;
			acc_bit2_o       <= 1'b0;
		end
		else if (ce_i)
		begin
			if (init_hold)
			begin
				sync_en <= 1'b1;
			end
			sync_clk_out_o   <= tk.cyc_stb && sync_en;
			// Crystal feedback only in crystal mode; other modes leave the pin to others
			clk_out_pin_oe_o <= (tk.mode == mirc_pkg::CM_CRYSTAL);
			clk_out_pin_o    <= (tk.mode == mirc_pkg::CM_CRYSTAL) && !tk.osc_lvl;
			if (latch_read_i)
			begin
				acc_bit2_o <= gpin_ok && pin_sync[mirc_pkg::PIN_CKO];
			end
		end
	end

	// Wishbone: answer one cycle after the request, drop ack the next cycle
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign wr_ctrl = wb_ack_o && bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mirc_pkg::OFS_CTRL;
	assign wr_opt  = wb_ack_o && bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mirc_pkg::OFS_OPTION;

	// Read mux; unmapped addresses read as zero and still acknowledge
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			mirc_pkg::OFS_CTRL:   rd_mux = 32'(ctrl);
			mirc_pkg::OFS_OPTION: rd_mux = 32'(opt);
			mirc_pkg::OFS_STATUS: rd_mux = 32'({stk[0][PCW], sync_en, init_hold, tk.irq_req});
			mirc_pkg::OFS_PC:     rd_mux = 32'(pc_o);
			default:
			begin
				if (wb_adr_i[7:4] == mirc_pkg::OFS_SLOT[7:4] && wb_adr_i[1:0] == 2'h0
					&& 32'(wb_adr_i[3:2]) < STACK_DEPTH)
				begin
					rd_mux = 32'(stk[wb_adr_i[3:2]]);
				end
			end
		endcase
	end

	// Bus answer and control register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl     <= mirc_pkg::CTRL_RST;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o)
			begin
				wb_dat_o <= rd_mux;
			end
			if (wr_ctrl)
			begin
				ctrl <= wb_dat_i[mirc_pkg::CTRL_W-1:0];
			end
		end
	end

	property p_ack_vector;
		@(posedge clk_i) disable iff (rst_i)
		irq_ack_o |-> pc_o == mirc_pkg::PC_VECTOR && $past(instr_done_i);
	endproperty
	a_ack_vector: assert property (p_ack_vector) else $error("acknowledge without vector jump");

	property p_ack_disarms;
		@(posedge clk_i) disable iff (rst_i)
		irq_ack_o && !$past(flag_load_i) && !$past(wr_opt)
			|-> $past(opt[mirc_pkg::OPT_ARM_BIT]) && !opt[mirc_pkg::OPT_ARM_BIT];
	endproperty
	a_ack_disarms: assert property (p_ack_disarms) else $error("arm bit wrong around acknowledge");

	property p_ack_push;
		@(posedge clk_i) disable iff (rst_i)
		take |=> stk[0] == {$past(skip_i), $past(target_pc_i)} && stk[1] == $past(stk[0]);
	endproperty
	a_ack_push: assert property (p_ack_push) else $error("stack push wrong on acknowledge");

	property p_chain_defers;
		@(posedge clk_i) disable iff (rst_i)
		instr_done_i && chain |=> !irq_ack_o;
	endproperty
	a_chain_defers: assert property (p_chain_defers) else $error("acknowledge inside a chain");

	property p_pop_restore;
		@(posedge clk_i) disable iff (rst_i)
		do_pop |=> skip_restore_o == $past(stk[0][PCW]) && pc_o == $past(stk[0][PCW-1:0]);
	endproperty
	a_pop_restore: assert property (p_pop_restore) else $error("pop lost saved skip");

	property p_init_clear;
		@(posedge clk_i) disable iff (rst_i)
		init_hold && ce_i |=> pc_o == mirc_pkg::PC_RESET && opt == mirc_pkg::OPT_RST;
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("initialisation left state");

	property p_init_low;
		@(posedge clk_i) disable iff (rst_i)
		$rose(core_clear_o) |-> !$past(pin_sync[mirc_pkg::PIN_RST])
			&& $past(low_cnt) == CW'(RST_HOLD - 1) && $past(tk.cyc_stb);
	endproperty
	a_init_low: assert property (p_init_low) else $error("initialised on short reset");

	property p_sync_pulse;
		@(posedge clk_i) disable iff (rst_i)
		sync_clk_out_o |-> $past(tk.cyc_stb) && !$past(sync_clk_out_o);
	endproperty
	a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse not per cycle");
endmodule : mirc_ctl
`default_nettype wire

// *** tb/mirc_peer.sv ***
// Far-side model: oscillator, interrupt source and synchronising peer chip.
// Assumes the bench clock; the interrupt pin idles high through its pull-up.
`timescale 1ns/100ps
`default_nettype none
module mirc_peer (
	input  wire logic       clk_i,
	input  wire logic       fire_i,
	input  wire logic [7:0] low_len_i,
	output logic            osc_o,
	output logic            irq_pin_o,
	output logic            sync_o
);
	logic [7:0] osc_cnt = 8'h00;
	logic [7:0] low_cnt = 8'h00;
	logic [7:0] syn_cnt = 8'h00;
	// Oscillator of eight clocks, slow enough for the pin synchroniser
	always_ff @(posedge clk_i)
		osc_cnt <= osc_cnt + 8'h01;
	assign osc_o = osc_cnt[2];
	// Low pulse of the requested length, then back to the pulled-up level
	always_ff @(posedge clk_i)
		low_cnt <= fire_i ? low_len_i : (low_cnt != 8'h00 ? low_cnt - 8'h01 : 8'h00);
	assign irq_pin_o = (low_cnt == 8'h00);
	// Peer sync: a four-clock pulse every 40 clocks, one per instruction cycle
	always_ff @(posedge clk_i)
		syn_cnt <= (syn_cnt == 8'h27) ? 8'h00 : syn_cnt + 8'h01;
	assign sync_o = (syn_cnt < 8'h04);
endmodule : mirc_peer
`default_nettype wire

// *** tb/mirc_ctl_tb_top.sv ***
// Testbench: bus, core and pin stimulus for the control block, scoreboard on reads.
// Assumes the peer model drives oscillator, interrupt and sync pins.
`timescale 1ns/100ps
`default_nettype none
module mirc_ctl_tb_top;
	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, fire = 1'b0, peer_sync;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0]  wb_adr_i = 8'h00, low_len = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf, flag_data_i = 4'h0, option_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [10:0] target_pc_i = 11'h000, pc_o, tgt;
	logic        reset_pin_n_i = 1'b1, instr_done_i = 1'b0, done_xfer_i = 1'b0;
	logic        done_ptr_i = 1'b0, next_xfer_i = 1'b0, next_ptr_i = 1'b0, push_i = 1'b0;
	logic        pop_i = 1'b0, skip_i = 1'b0, flag_load_i = 1'b0, latch_read_i = 1'b0;
	logic        clk_in_pin_i, irq_pin_i, clk_out_pin_i, clk_out_pin_o, clk_out_pin_oe_o;
	logic        sync_clk_out_o, seg_oe_o, cyc_stb_o, irq_ack_o, skip_restore_o;
	logic        core_clear_o, acc_bit2_o;
	logic [16:0] lfsr = 17'h11c7e;
	logic [31:0] exp_q[$];
	logic [4:0]  mode_ctl[6] = '{5'h00, 5'h04, 5'h08, 5'h01, 5'h02, 5'h03};
	int          mode_gap[6] = '{256, 128, 64, 256, 32, 40};
	int          err_count = 0, total_checks = 0, cycles = 0;
	// Clock; the shared pin shows the block while it drives, else the peer
	always #2 clk_i = ~clk_i;
	assign clk_out_pin_i = clk_out_pin_oe_o ? clk_out_pin_o : peer_sync;
	mirc_ctl mirc_ctl_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .clk_in_pin_i, .irq_pin_i, .reset_pin_n_i,
		.clk_out_pin_i, .clk_out_pin_o, .clk_out_pin_oe_o, .sync_clk_out_o, .seg_oe_o,
		.instr_done_i, .done_xfer_i, .done_ptr_i, .next_xfer_i, .next_ptr_i, .push_i, .pop_i,
		.target_pc_i, .skip_i, .flag_load_i, .flag_data_i, .latch_read_i, .cyc_stb_o, .pc_o,
		.irq_ack_o, .skip_restore_o, .core_clear_o, .option_o, .acc_bit2_o);
	mirc_peer mirc_peer_i (.clk_i, .fire_i(fire), .low_len_i(low_len), .osc_o(clk_in_pin_i),
		.irq_pin_o(irq_pin_i), .sync_o(peer_sync));
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr_next
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	// Classic cycle: request held until ack is sampled, released at that edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
		// Ends when ack is seen; the hang guard ends it if ack never comes
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	task automatic rd(input logic [7:0] adr, input logic [31:0] want);
		exp_q.push_back(want);
		wb(1'b0, adr, 32'h0);
	endtask : rd
	// One completion; outputs looked at once the following edge has landed
	task automatic done(input logic x, input logic p, input logic pp, input logic sk);
		@(posedge clk_i);
		{instr_done_i, done_xfer_i, next_xfer_i, done_ptr_i, next_ptr_i, pop_i, skip_i} <=
			{1'b1, x, x, p, p, pp, sk};
		target_pc_i <= tgt;
		@(posedge clk_i);
		{instr_done_i, done_xfer_i, next_xfer_i, done_ptr_i, next_ptr_i, pop_i, skip_i} <= 7'h00;
		#1;
	endtask : done
	task automatic pulse(input logic [7:0] len);
		@(posedge clk_i);
		{fire, low_len} <= {1'b1, len};
		@(posedge clk_i);
		fire <= 1'b0;
		repeat (160) @(posedge clk_i);
	endtask : pulse
	// Distance between strobes, measured after two settling strobes
	task automatic gap(input logic which, input int want);
		int k, m;
		for (k = 0; k < 3; k++)
		begin
			m = 0;
			do
			begin
				@(posedge clk_i);
				m++;
			end
			while ((which ? sync_clk_out_o : cyc_stb_o) !== 1'b1 && m < 600);
		end
		check("strobe gap", 32'(m), 32'(want));
	endtask : gap
	// Scoreboard: oldest read note against each read answer
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			check("wb_dat_o", wb_dat_o, exp_q.pop_front());
	// Hang guard, well above the few thousand cycles the sequence needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			results();
		end
	end
	initial
	begin
		tgt = 11'h000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'hfc, 32'h0);
		check("sync_clk_out_o", 32'(sync_clk_out_o), 32'h0);
		foreach (mode_ctl[i])
		begin
			wb(1'b1, 8'h00, {27'h0, mode_ctl[i]});
			gap(1'b0, mode_gap[i]);
			check("pin_oe", 32'(clk_out_pin_oe_o), 32'(mode_ctl[i][1:0] == 2'h0));
		end
		// Pin initialisation in RC mode: a short low is ignored, a long one clears
		wb(1'b1, 8'h00, 32'h2);
		wb(1'b1, 8'h04, 32'hf); // All ones
		reset_pin_n_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		check("core_clear_o", 32'(core_clear_o), 32'h0);
		reset_pin_n_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		reset_pin_n_i <= 1'b0;
		repeat (160) @(posedge clk_i);
		check("core_clear_o", 32'(core_clear_o), 32'h1);
		check("pc_o", 32'(pc_o), 32'h0);
		check("option_o", 32'(option_o), 32'h0);
		reset_pin_n_i <= 1'b1;
		gap(1'b1, 32);
		// Interrupt gating: disarmed, too short, pending, chained, then taken
		pulse(8'h78);
		done(1'b0, 1'b0, 1'b0, 1'b0); // Accumulator clear at address zero
		check("irq_ack_o", 32'(irq_ack_o), 32'h0);
		wb(1'b1, 8'h04, 32'h6);
		#1;
		check("seg_oe_o", 32'(seg_oe_o), 32'h1);
		pulse(8'h14);
		done(1'b0, 1'b0, 1'b0, 1'b0);
		check("irq_ack_o", 32'(irq_ack_o), 32'h0);
		pulse(8'h78);
		check("irq_ack_o", 32'(irq_ack_o), 32'h0);
		done(1'b1, 1'b0, 1'b0, 1'b0);
		check("irq_ack_o", 32'(irq_ack_o), 32'h0);
		done(1'b0, 1'b1, 1'b0, 1'b0);
		check("irq_ack_o", 32'(irq_ack_o), 32'h0);
		repeat (5) lfsr = lfsr_next(lfsr);
		tgt = lfsr[10:0];
		done(1'b0, 1'b0, 1'b0, 1'b1);
		check("irq_ack_o", 32'(irq_ack_o), 32'h1);
		check("pc_o", 32'(pc_o), 32'h0ff);
		check("option_o", 32'(option_o), 32'h4);
		rd(8'h10, {20'h0, 1'b1, tgt});
		done(1'b0, 1'b0, 1'b0, 1'b0); // Idle op first at the vector
		done(1'b0, 1'b0, 1'b1, 1'b0); // Plain return, nothing nested
		check("skip_restore_o", 32'(skip_restore_o), 32'h1);
		@(posedge clk_i);
		{flag_load_i, flag_data_i} <= 5'h16;
		@(posedge clk_i);
		flag_load_i <= 1'b0;
		#1;
		check("option_o", 32'(option_o), 32'h6);
		// Clock-output pin as plain input in RC mode, read while the peer holds it high
		wb(1'b1, 8'h00, 32'h12);
		@(posedge clk_i iff peer_sync === 1'b1);
		@(posedge clk_i);
		latch_read_i <= 1'b1;
		@(posedge clk_i);
		latch_read_i <= 1'b0;
		#1;
		check("acc_bit2_o", 32'(acc_bit2_o), 32'h1);
		check("clk_out_pin_o", 32'(clk_out_pin_o), 32'h0);
		results();
	end
endmodule : mirc_ctl_tb_top
`default_nettype wire
